/* common/dtc_pkg.sv */
// shared constants, timing figures and types of the drive timing configuration block
`default_nettype none
package dtc_pkg;
    // register map
    localparam logic [7:0] DTC_CFG_ADDR = 8'h29;
    localparam logic [7:0] DTC_STATUS_ADDR = 8'h30;
    localparam logic [7:0] DTC_CFG_MASK = 8'h3F;
    // field positions within the configuration register
    localparam int DTC_ZC_LSB = 0;
    localparam int DTC_SAMPLE_LSB = 2;
    localparam int DTC_CLAMP_LSB = 4;
    localparam int DTC_FIELD_W = 2;
    // field reset values
    localparam logic [1:0] DTC_CLAMP_RST = 2'h0;
    localparam logic [1:0] DTC_SAMPLE_RST = 2'h3;
    localparam logic [1:0] DTC_ZC_RST = 2'h0;
    localparam logic [1:0] DTC_CLAMP_OFF = 2'h0;
    // status register bit positions
    localparam int DTC_ST_AUTO = 0;
    localparam int DTC_ST_TIMING = 1;
    localparam int DTC_ST_CLAMPED = 2;
    localparam int DTC_ST_SAMPLE = 3;
    localparam int DTC_ST_WINDOW = 4;
    // clock and counter width
    localparam int DTC_CLK_PERIOD_NS = 10;
    localparam int DTC_CNT_W = 24;
    // overdrive clamp limits in ms: longest times, rounded down
    localparam int DTC_CLAMP1_MS = 25;
    localparam int DTC_CLAMP2_MS = 50;
    localparam int DTC_CLAMP3_MS = 100;
    localparam int DTC_CLAMP1_CYC = DTC_CLAMP1_MS * 1000000 / DTC_CLK_PERIOD_NS;
    localparam int DTC_CLAMP2_CYC = DTC_CLAMP2_MS * 1000000 / DTC_CLK_PERIOD_NS;
    localparam int DTC_CLAMP3_CYC = DTC_CLAMP3_MS * 1000000 / DTC_CLK_PERIOD_NS;
    // back-emf sample delays in us: least times, rounded up
    localparam int DTC_SAMPLE0_US = 150;
    localparam int DTC_SAMPLE1_US = 200;
    localparam int DTC_SAMPLE2_US = 250;
    localparam int DTC_SAMPLE3_US = 300;
    localparam int DTC_SAMPLE0_CYC =
        (DTC_SAMPLE0_US * 1000 + DTC_CLK_PERIOD_NS - 1) / DTC_CLK_PERIOD_NS;
    localparam int DTC_SAMPLE1_CYC =
        (DTC_SAMPLE1_US * 1000 + DTC_CLK_PERIOD_NS - 1) / DTC_CLK_PERIOD_NS;
    localparam int DTC_SAMPLE2_CYC =
        (DTC_SAMPLE2_US * 1000 + DTC_CLK_PERIOD_NS - 1) / DTC_CLK_PERIOD_NS;
    localparam int DTC_SAMPLE3_CYC =
        (DTC_SAMPLE3_US * 1000 + DTC_CLK_PERIOD_NS - 1) / DTC_CLK_PERIOD_NS;
    // zero-crossing detection windows in us: longest times, rounded down
    localparam int DTC_ZC0_US = 100;
    localparam int DTC_ZC1_US = 200;
    localparam int DTC_ZC2_US = 300;
    localparam int DTC_ZC3_US = 390;
    localparam int DTC_ZC0_CYC = DTC_ZC0_US * 1000 / DTC_CLK_PERIOD_NS;
    localparam int DTC_ZC1_CYC = DTC_ZC1_US * 1000 / DTC_CLK_PERIOD_NS;
    localparam int DTC_ZC2_CYC = DTC_ZC2_US * 1000 / DTC_CLK_PERIOD_NS;
    localparam int DTC_ZC3_CYC = DTC_ZC3_US * 1000 / DTC_CLK_PERIOD_NS;

    // overdrive clamp sequencer states
    typedef enum logic [1:0] {
        DTC_CL_IDLE = 2'b00,
        DTC_CL_TIMING = 2'b01,
        DTC_CL_CLAMPED = 2'b10
    } dtc_clamp_state_type;

    // pick one of four cycle counts by a two-bit code
    function automatic logic [DTC_CNT_W-1:0] dtc_pick(input logic [1:0] code,
        input int c0, input int c1, input int c2, input int c3);
        logic [DTC_CNT_W-1:0] r;
        unique case (code)
            2'h0: r = DTC_CNT_W'(c0);
            2'h1: r = DTC_CNT_W'(c1);
            2'h2: r = DTC_CNT_W'(c2);
            2'h3: r = DTC_CNT_W'(c3);
        endcase
        return r;
    endfunction : dtc_pick
endpackage : dtc_pkg
`default_nettype wire

/* common/dtc_cfg_if.sv */
// decoded configuration fields passed from the register bank to the timing engine
`default_nettype none
interface dtc_cfg_if;
    logic [1:0] clamp_sel;
    logic [1:0] sample_code;
    logic [1:0] zc_code;
    modport regs (output clamp_sel, output sample_code, output zc_code);
    modport engine (input clamp_sel, input sample_code, input zc_code);
endinterface : dtc_cfg_if
`default_nettype wire

/* design/dtc_regfile.sv */
// configuration and status register bank on the plain register port
`default_nettype none
module dtc_regfile (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // live engine state and decoded fields
    input wire logic [7:0] status,
    dtc_cfg_if.regs cfg
);
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // write decode, reserved bits stay zero; read data live one cycle only
    always_comb begin
        cfg_next = cfg_reg;
        rdata_next = 8'h00;
        if (wr && addr == dtc_pkg::DTC_CFG_ADDR) begin
            cfg_next = wdata & dtc_pkg::DTC_CFG_MASK;
        end
        if (rd) begin
            unique case (addr)
                dtc_pkg::DTC_CFG_ADDR: rdata_next = cfg_reg;
                dtc_pkg::DTC_STATUS_ADDR: rdata_next = status;
                default: rdata_next = 8'h00; // unmapped reads as zero
            endcase
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_reg <= {2'h0, dtc_pkg::DTC_CLAMP_RST, dtc_pkg::DTC_SAMPLE_RST,
                dtc_pkg::DTC_ZC_RST};
            rdata_reg <= 8'h00;
        end else if (ce) begin
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    // field slices toward the engine
    assign cfg.clamp_sel = cfg_reg[dtc_pkg::DTC_CLAMP_LSB +: dtc_pkg::DTC_FIELD_W];
    assign cfg.sample_code = cfg_reg[dtc_pkg::DTC_SAMPLE_LSB +: dtc_pkg::DTC_FIELD_W];
    assign cfg.zc_code = cfg_reg[dtc_pkg::DTC_ZC_LSB +: dtc_pkg::DTC_FIELD_W];
    assign rdata = rdata_reg;
endmodule : dtc_regfile
`default_nettype wire

/* design/dtc_delay_timer.sv */
// loadable one-shot down counter with abort, busy level and done pulse
`default_nettype none
module dtc_delay_timer #(
    parameter int CNT_W = 24
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // control
    input wire logic load,
    input wire logic abort,
    input wire logic [CNT_W-1:0] count,
    // state
    output logic busy,
    output logic done
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    logic done_reg;
    logic done_next;

    // refuse a counter too narrow to be useful
    if (CNT_W < 2) begin : g_chk
        $error("dtc_delay_timer: CNT_W must be at least 2");
    end

    // load restarts, abort cancels, done pulses count cycles after load
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (load) begin
            cnt_next = count;
            busy_next = 1'b1;
        end else if (abort) begin
            busy_next = 1'b0;
        end else if (busy_reg) begin
            cnt_next = cnt_reg - CNT_W'(1);
            if (cnt_reg <= CNT_W'(1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule : dtc_delay_timer
`default_nettype wire

/* design/dtc_top.sv */
// drive timing configuration register with its clamp, sample and detection timers
//
// Chosen here: the address-and-strobe port.
`default_nettype none

// Functional notes
// - clamp codes 1..3 limit 25/50/100 ms
// - clamp code zero means automatic, unlimited overdrive
// - after clamp period, clamp to rated level
// - autocal or diagnostics ignore clamp, use automatic
// - back-emf sample delay 150..300 us, reset 3
// - zero-cross detection window 100..390 us, reset 0
module dtc_top #(
    // clamp limits in cycles
    parameter int CLAMP1_CYC = dtc_pkg::DTC_CLAMP1_CYC,
    parameter int CLAMP2_CYC = dtc_pkg::DTC_CLAMP2_CYC,
    parameter int CLAMP3_CYC = dtc_pkg::DTC_CLAMP3_CYC,
    // back-emf sample delays in cycles
    parameter int SAMPLE0_CYC = dtc_pkg::DTC_SAMPLE0_CYC,
    parameter int SAMPLE1_CYC = dtc_pkg::DTC_SAMPLE1_CYC,
    parameter int SAMPLE2_CYC = dtc_pkg::DTC_SAMPLE2_CYC,
    parameter int SAMPLE3_CYC = dtc_pkg::DTC_SAMPLE3_CYC,
    // zero-crossing windows in cycles
    parameter int ZC0_CYC = dtc_pkg::DTC_ZC0_CYC,
    parameter int ZC1_CYC = dtc_pkg::DTC_ZC1_CYC,
    parameter int ZC2_CYC = dtc_pkg::DTC_ZC2_CYC,
    parameter int ZC3_CYC = dtc_pkg::DTC_ZC3_CYC
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // drive loop events and modes
    input wire logic od_phase_start,
    input wire logic od_phase_active,
    input wire logic autocal_active,
    input wire logic diag_active,
    input wire logic zero_cross,
    input wire logic zc_search_start,
    // overdrive clamp toward the drive loop
    output logic [1:0] overdrive_clamp_sel,
    output logic auto_overdrive,
    output logic [23:0] od_limit_cycles,
    output logic clamp_to_rated,
    // back-emf sampling toward the adc
    output logic [23:0] sample_delay_cycles,
    output logic back_emf_sample,
    // zero-crossing detection
    output logic [23:0] zero_cross_window,
    output logic zc_window_open,
    output logic zc_detected,
    output logic zc_timeout
);
    localparam int CW = dtc_pkg::DTC_CNT_W;
    localparam longint CMAX = (64'd1 << CW) - 64'd1;

    // refuse counts the timers cannot hold
    function automatic bit dtc_bad(input int c);
        return (c < 1) || (longint'(c) > CMAX);
    endfunction : dtc_bad

    if (dtc_bad(CLAMP1_CYC) || dtc_bad(CLAMP2_CYC) || dtc_bad(CLAMP3_CYC))
    begin : g_chk_clamp
        $error("dtc_top: clamp counts out of range");
    end
    if (dtc_bad(SAMPLE0_CYC) || dtc_bad(SAMPLE1_CYC) || dtc_bad(SAMPLE2_CYC)
        || dtc_bad(SAMPLE3_CYC)) begin : g_chk_sample
        $error("dtc_top: sample counts out of range");
    end
    if (dtc_bad(ZC0_CYC) || dtc_bad(ZC1_CYC) || dtc_bad(ZC2_CYC)
        || dtc_bad(ZC3_CYC)) begin : g_chk_zc
        $error("dtc_top: window counts out of range");
    end

    // decoded fields from the register bank
    dtc_cfg_if cfg ();

    // engine state
    dtc_pkg::dtc_clamp_state_type cl_state_reg;
    dtc_pkg::dtc_clamp_state_type cl_state_next;
    logic [CW-1:0] od_cyc_reg;
    logic [CW-1:0] od_cyc_next;
    logic [CW-1:0] smp_cyc_reg;
    logic [CW-1:0] smp_cyc_next;
    logic [CW-1:0] zc_cyc_reg;
    logic [CW-1:0] zc_cyc_next;
    logic zc_det_reg;
    logic zc_det_next;
    logic [7:0] status;

    // timer controls
    logic cl_load;
    logic cl_abort;
    logic cl_busy;
    logic cl_done;
    logic smp_busy;
    logic smp_done;
    logic zc_busy;
    logic zc_done;
    logic zc_abort;
    logic clamp_ignored;
    logic auto_od;

    // register bank
    dtc_regfile u_regs (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .wr(reg_wr),
        .rd(reg_rd),
        .rdata(reg_rdata),
        .status(status),
        .cfg(cfg.regs)
    );

    // mode decode: clamp select is moot during calibration or diagnostics
    assign clamp_ignored = autocal_active | diag_active;
    assign auto_od = (cfg.clamp_sel == dtc_pkg::DTC_CLAMP_OFF) | clamp_ignored;

    // decoded cycle counts, registered so the data outputs come from flops
    always_comb begin
        od_cyc_next = dtc_pkg::dtc_pick(cfg.clamp_sel, CLAMP1_CYC, CLAMP1_CYC,
            CLAMP2_CYC, CLAMP3_CYC);
        smp_cyc_next = dtc_pkg::dtc_pick(cfg.sample_code, SAMPLE0_CYC, SAMPLE1_CYC,
            SAMPLE2_CYC, SAMPLE3_CYC);
        zc_cyc_next = dtc_pkg::dtc_pick(cfg.zc_code, ZC0_CYC, ZC1_CYC,
            ZC2_CYC, ZC3_CYC);
        if (cfg.clamp_sel == dtc_pkg::DTC_CLAMP_OFF) begin
            od_cyc_next = '0; // no limit for clamp code zero
        end
    end

    // clamp sequencer: times the overdrive or braking phase, then clamps
    always_comb begin
        cl_state_next = cl_state_reg;
        cl_load = 1'b0;
        cl_abort = 1'b0;
        unique case (cl_state_reg)
            dtc_pkg::DTC_CL_IDLE: begin
                if (od_phase_start && od_phase_active && !auto_od) begin
                    cl_load = 1'b1;
                    cl_state_next = dtc_pkg::DTC_CL_TIMING;
                end
            end
            dtc_pkg::DTC_CL_TIMING: begin
                if (!od_phase_active || auto_od) begin
                    cl_abort = 1'b1;
                    cl_state_next = dtc_pkg::DTC_CL_IDLE;
                end else if (cl_done) begin
                    cl_state_next = dtc_pkg::DTC_CL_CLAMPED;
                end
            end
            dtc_pkg::DTC_CL_CLAMPED: begin
                if (!od_phase_active || auto_od) begin
                    cl_state_next = dtc_pkg::DTC_CL_IDLE;
                end
            end
            default: cl_state_next = dtc_pkg::DTC_CL_IDLE; // illegal code
        endcase
    end

    // a zero crossing inside an open window ends the search early
    always_comb begin
        zc_abort = zero_cross & zc_busy & ~zc_search_start;
        zc_det_next = zc_abort;
    end

    // register stage of the engine
    always_ff @(posedge clk) begin
        if (srst) begin
            cl_state_reg <= dtc_pkg::DTC_CL_IDLE;
            od_cyc_reg <= '0;
            smp_cyc_reg <= '0;
            zc_cyc_reg <= '0;
            zc_det_reg <= 1'b0;
        end else if (ce) begin
            cl_state_reg <= cl_state_next;
            od_cyc_reg <= od_cyc_next;
            smp_cyc_reg <= smp_cyc_next;
            zc_cyc_reg <= zc_cyc_next;
            zc_det_reg <= zc_det_next;
        end
    end

    // overdrive clamp period timer, loaded with the live decode
    dtc_delay_timer #(
        .CNT_W(CW)
    ) u_clamp_tmr (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .load(cl_load),
        .abort(cl_abort),
        .count(od_cyc_next),
        .busy(cl_busy),
        .done(cl_done)
    );

    // back-emf sample delay, restarted by each zero crossing
    dtc_delay_timer #(
        .CNT_W(CW)
    ) u_sample_tmr (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .load(zero_cross),
        .abort(1'b0),
        .count(smp_cyc_next),
        .busy(smp_busy),
        .done(smp_done)
    );

    // zero-crossing detection window
    dtc_delay_timer #(
        .CNT_W(CW)
    ) u_zc_tmr (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .load(zc_search_start),
        .abort(zc_abort),
        .count(zc_cyc_next),
        .busy(zc_busy),
        .done(zc_done)
    );

    // live engine state for software
    always_comb begin
        status = 8'h00;
        status[dtc_pkg::DTC_ST_AUTO] = auto_od;
        status[dtc_pkg::DTC_ST_TIMING] = cl_busy;
        status[dtc_pkg::DTC_ST_CLAMPED] = (cl_state_reg == dtc_pkg::DTC_CL_CLAMPED);
        status[dtc_pkg::DTC_ST_SAMPLE] = smp_busy;
        status[dtc_pkg::DTC_ST_WINDOW] = zc_busy;
    end

    // outputs toward the drive loop
    assign overdrive_clamp_sel = cfg.clamp_sel;
    assign auto_overdrive = auto_od;
    assign od_limit_cycles = od_cyc_reg;
    assign clamp_to_rated = (cl_state_reg == dtc_pkg::DTC_CL_CLAMPED);
    assign sample_delay_cycles = smp_cyc_reg;
    assign back_emf_sample = smp_done;
    assign zero_cross_window = zc_cyc_reg;
    assign zc_window_open = zc_busy;
    assign zc_detected = zc_det_reg;
    assign zc_timeout = zc_done;
endmodule : dtc_top
`default_nettype wire

/* verif/dtc_top_props.sv */
// assertion checker for the drive timing configuration top
`default_nettype none
module dtc_top_props #(
    parameter int CLAMP1_CYC = 1
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // drive loop events and modes
    input wire logic od_phase_start,
    input wire logic od_phase_active,
    input wire logic autocal_active,
    input wire logic diag_active,
    input wire logic zero_cross,
    input wire logic zc_search_start,
    // clamp, sampling and detection outputs
    input wire logic [1:0] overdrive_clamp_sel,
    input wire logic auto_overdrive,
    input wire logic [23:0] od_limit_cycles,
    input wire logic clamp_to_rated,
    input wire logic [23:0] sample_delay_cycles,
    input wire logic back_emf_sample,
    input wire logic [23:0] zero_cross_window,
    input wire logic zc_window_open,
    input wire logic zc_detected,
    input wire logic zc_timeout
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [23:0] od_age_reg;
    logic [23:0] xing_age_reg;
    logic [23:0] win_age_reg;

    // cycle ages since phase begin, last crossing and last window start
    always_ff @(posedge clk) begin
        if (srst) begin
            od_age_reg <= 24'h00_0000;
            xing_age_reg <= 24'h00_0000;
            win_age_reg <= 24'h00_0000;
        end else if (ce) begin
            od_age_reg <= (od_phase_active && !auto_overdrive) ?
                od_age_reg + 24'h00_0001 : 24'h00_0000;
            xing_age_reg <= zero_cross ? 24'h00_0001 : xing_age_reg + 24'h00_0001;
            win_age_reg <= zc_search_start ? 24'h00_0001 : win_age_reg + 24'h00_0001;
        end
    end

    // clamp code to the current od_limit_cycles, zero for clamp code zero
    function automatic logic [23:0] clamp_dec(input logic [1:0] s);
        return (s == 2'h0) ? 24'h00_0000 : od_limit_cycles;
    endfunction : clamp_dec

    a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_read_cfg: assert property (ce && reg_rd && reg_addr == 8'h29
        |=> reg_rdata[7:6] == 2'h0 && reg_rdata[5:4] == $past(overdrive_clamp_sel))
        else $error("configuration readback wrong");
    a_auto_mode: assert property (auto_overdrive
        == (overdrive_clamp_sel == 2'h0 || autocal_active || diag_active))
        else $error("automatic overdrive level wrong");
    a_limit_zero: assert property (ce && overdrive_clamp_sel == 2'h0
        ##1 overdrive_clamp_sel == 2'h0 |-> od_limit_cycles == 24'h00_0000)
        else $error("clamp limit not zero in automatic mode");
    a_clamp_early: assert property ($rose(clamp_to_rated) |-> od_age_reg >= 24'(CLAMP1_CYC))
        else $error("clamp came before the shortest period");
    a_clamp_release: assert property (clamp_to_rated && (!od_phase_active || auto_overdrive)
        |=> !clamp_to_rated)
        else $error("clamp held after phase end or in automatic mode");
    a_sample_pulse: assert property (back_emf_sample |=> !back_emf_sample)
        else $error("sample pulse longer than one cycle");
    a_sample_delay: assert property (back_emf_sample
        |-> xing_age_reg == sample_delay_cycles + 24'h00_0001)
        else $error("sample not at the programmed delay");
    a_zc_detect: assert property (ce && zc_window_open && zero_cross && !zc_search_start
        |=> zc_detected && !zc_window_open)
        else $error("crossing inside window not reported");
    a_zc_timeout: assert property (zc_timeout
        |-> win_age_reg == zero_cross_window + 24'h00_0001)
        else $error("window timeout at wrong cycle");

    c_clamp: cover property ($rose(clamp_to_rated));
    c_sample: cover property (back_emf_sample);
    c_detect: cover property (zc_detected);
    c_timeout: cover property (zc_timeout);
endmodule : dtc_top_props

bind dtc_top dtc_top_props #(.CLAMP1_CYC(CLAMP1_CYC)) u_props (
    .clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .od_phase_start(od_phase_start), .od_phase_active(od_phase_active),
    .autocal_active(autocal_active), .diag_active(diag_active), .zero_cross(zero_cross),
    .zc_search_start(zc_search_start), .overdrive_clamp_sel(overdrive_clamp_sel),
    .auto_overdrive(auto_overdrive), .od_limit_cycles(od_limit_cycles),
    .clamp_to_rated(clamp_to_rated), .sample_delay_cycles(sample_delay_cycles),
    .back_emf_sample(back_emf_sample), .zero_cross_window(zero_cross_window),
    .zc_window_open(zc_window_open), .zc_detected(zc_detected), .zc_timeout(zc_timeout));
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the drive timing configuration top
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts per code
    localparam int CL1 = 20;
    localparam int CL2 = 30;
    localparam int CL3 = 40;
    localparam int SM0 = 3;
    localparam int SM1 = 4;
    localparam int SM2 = 5;
    localparam int SM3 = 6;
    localparam int ZW0 = 5;
    localparam int ZW1 = 6;
    localparam int ZW2 = 7;
    localparam int ZW3 = 8;
    int clamp_c[4] = '{0, CL1, CL2, CL3};
    int samp_c[4] = '{SM0, SM1, SM2, SM3};
    int zc_c[4] = '{ZW0, ZW1, ZW2, ZW3};
    int fail_count = 0;
    int compares = 0;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic od_phase_start = 1'b0;
    logic od_phase_active = 1'b0;
    logic autocal_active = 1'b0;
    logic diag_active = 1'b0;
    logic zero_cross = 1'b0;
    logic zc_search_start = 1'b0;
    logic [1:0] overdrive_clamp_sel;
    logic auto_overdrive;
    logic clamp_to_rated;
    logic back_emf_sample;
    logic zc_window_open;
    logic zc_detected;
    logic zc_timeout;
    logic [23:0] od_limit_cycles;
    logic [23:0] sample_delay_cycles;
    logic [23:0] zero_cross_window;

    always #5 clk = ~clk;

    dtc_top #(.CLAMP1_CYC(CL1), .CLAMP2_CYC(CL2), .CLAMP3_CYC(CL3), .SAMPLE0_CYC(SM0),
        .SAMPLE1_CYC(SM1), .SAMPLE2_CYC(SM2), .SAMPLE3_CYC(SM3), .ZC0_CYC(ZW0),
        .ZC1_CYC(ZW1), .ZC2_CYC(ZW2), .ZC3_CYC(ZW3)) DUT (
        .clk(clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .od_phase_start(od_phase_start), .od_phase_active(od_phase_active),
        .autocal_active(autocal_active), .diag_active(diag_active),
        .zero_cross(zero_cross), .zc_search_start(zc_search_start),
        .overdrive_clamp_sel(overdrive_clamp_sel), .auto_overdrive(auto_overdrive),
        .od_limit_cycles(od_limit_cycles), .clamp_to_rated(clamp_to_rated),
        .sample_delay_cycles(sample_delay_cycles), .back_emf_sample(back_emf_sample),
        .zero_cross_window(zero_cross_window), .zc_window_open(zc_window_open),
        .zc_detected(zc_detected), .zc_timeout(zc_timeout));

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // pulse one event input, then count cycles until the watched output is high
    task automatic hit(input int k, output int n);
        @(posedge clk);
        if (k == 0) od_phase_start <= 1'b1;
        else if (k == 2) zc_search_start <= 1'b1;
        else zero_cross <= 1'b1;
        @(posedge clk);
        od_phase_start <= 1'b0;
        zc_search_start <= 1'b0;
        zero_cross <= 1'b0;
        n = 0;
        for (int i = 1; i < 60 && n == 0; i++) begin
            #1;
            if ((k == 0 && clamp_to_rated) || (k == 1 && back_emf_sample) ||
                (k == 2 && zc_timeout) || (k == 3 && zc_detected)) n = i;
            else @(posedge clk);
        end
    endtask : hit

    task automatic t_reset;
        logic [7:0] v;
        rd(8'h29, v);
        chk("cfg", 24'h00_000C, 24'(v));
        chk("sample", 24'(samp_c[3]), sample_delay_cycles);
        chk("window", 24'(zc_c[0]), zero_cross_window);
        chk("auto", 24'h00_0001, 24'(auto_overdrive));
        rd(8'h30, v);
        chk("status", 24'h00_0001, 24'(v));
    endtask : t_reset

    // writes while the enable is low must not land
    task automatic t_ce;
        logic [7:0] v;
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h29, 8'h15);
        ce <= 1'b1;
        rd(8'h29, v);
        chk("frozen", 24'h00_003F, 24'(v));
    endtask : t_ce

    task automatic t_regs;
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            wr(8'h29, {2'b11, 2'(c), 2'(c), 2'(c)});
            rd(8'h29, v);
            chk("cfg", 24'({2'b00, 2'(c), 2'(c), 2'(c)}), 24'(v));
            chk("limit", 24'(clamp_c[c]), od_limit_cycles);
            chk("sample", 24'(samp_c[c]), sample_delay_cycles);
            chk("window", 24'(zc_c[c]), zero_cross_window);
        end
        wr(8'h2A, 8'h15);
        wr(8'h30, 8'h00);
        rd(8'h29, v);
        chk("cfg", 24'h00_003F, 24'(v));
        rd(8'h2A, v);
        chk("unmapped", 24'h00_0000, 24'(v));
    endtask : t_regs

    task automatic t_clamp;
        int n;
        for (int s = 0; s < 6; s++) begin
            wr(8'h29, {2'b00, 2'(s > 3 ? 3 : s), 4'h0});
            @(posedge clk);
            autocal_active <= (s == 4);
            diag_active <= (s == 5);
            od_phase_active <= 1'b1;
            hit(0, n);
            chk("clamp", (s == 0 || s > 3) ? 24'h00_0000 : 24'(clamp_c[s] + 2),
                24'(n));
            @(posedge clk);
            od_phase_active <= 1'b0;
            autocal_active <= 1'b0;
            diag_active <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk("released", 24'h00_0000, 24'(clamp_to_rated));
        end
    endtask : t_clamp

    task automatic t_sample;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(8'h29, {4'h0, 2'(c), 2'b00});
            hit(1, n);
            chk("sample", 24'(samp_c[c] + 1), 24'(n));
        end
    endtask : t_sample

    task automatic t_zc;
        int n;
        for (int c = 0; c < 4; c++) begin
            wr(8'h29, {6'h00, 2'(c)});
            hit(2, n);
            chk("timeout", 24'(zc_c[c] + 1), 24'(n));
        end
        @(posedge clk);
        zc_search_start <= 1'b1;
        @(posedge clk);
        zc_search_start <= 1'b0;
        hit(3, n);
        chk("detect", 24'h00_0001, 24'(n));
    endtask : t_zc

    task automatic end_sim;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_ce();
        t_clamp();
        t_sample();
        t_zc();
        end_sim();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
